// *** logic/acc_ctrl.sv ***
// converter setup register and conversion sequencer with its serial slave
`default_nettype none

module acc_ctrl #(
    parameter logic [6:0] DEV_ADDR = acc_pkg::DEV_ADDR_DEF
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic scl_clk,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic comp_in,
    output logic [acc_pkg::CODE_W-1:0] dac_code,
    output logic track_en,
    output logic power_up,
    output logic [1:0] mux_sel,
    output logic [acc_pkg::CH_NUM-1:0] input_select_bits,
    output logic ref_from_shared_pin,
    output logic bus_glitch_filter_bypass,
    output logic conv_abort
);
    import acc_pkg::*;

    logic comp_s;
    logic [1:0] pin_s;
    logic [FILT_LEN-1:0] hist_q [2];
    logic [1:0] line_q;
    logic [1:0] prev_q;
    logic start_ev;
    logic stop_ev;
    logic busy_q;
    logic link_rst_q;
    logic [7:0] act_q;
    logic [1:0] tgl_s;
    logic [1:0] tgl_prev_q;
    logic cfg_ev;
    logic rd_ev;
    logic [7:0] link_cfg;
    logic link_cfg_tgl;
    logic link_rd_tgl;
    logic [7:0] setup_q;
    logic [CH_NUM-1:0] ch_en;
    logic [1:0] ch_q;
    logic [1:0] nxt_ch;
    acc_state_t state_q;
    logic [7:0] cnt_q;
    logic [3:0] bit_q;
    logic [CODE_W-1:0] code_q;
    logic [7:0] dly_q;
    logic abort_q;
    logic [RES_W-1:0] res_q;
    logic stretch_q;
    logic scl_oe_q;
    logic samp_hold;
    logic trial_hold;

    // ------------------------------------------------------------
    // pin sampling and bus line glitch filter
    // ------------------------------------------------------------

    // comparator, data and clock lines cross into sys_clk
    acc_sync #(
        .W(3)
    ) u_pin_sync (
        .clk(sys_clk),
        .rst(rst),
        .d({comp_in, sda_in, scl_clk}),
        .q({comp_s, pin_s})
    );

    // a line changes only after FILT_LEN equal samples unless bypassed
    for (genvar i = 0; i < 2; i++)
    begin : g_filt
        always_ff @(posedge sys_clk)
        begin
            if (rst)
            begin
                hist_q[i] <= '1;
                line_q[i] <= 1'b1;
            end
            else
            begin
                hist_q[i] <= {hist_q[i][FILT_LEN-2:0], pin_s[i]};
                if (setup_q[FLT_BIT])
                    line_q[i] <= pin_s[i];
                else if (&hist_q[i])
                    line_q[i] <= 1'b1;
                else if (~|hist_q[i])
                    line_q[i] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // frame detection and bus activity
    // ------------------------------------------------------------

    // start: data falls while clock high; stop: data rises while clock high
    assign start_ev = line_q[0] && prev_q[0] && prev_q[1] && !line_q[1];
    assign stop_ev = line_q[0] && prev_q[0] && !prev_q[1] && line_q[1];

    // frame state; link logic is held cleared between frames and at each start
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            prev_q <= 2'b11;
            busy_q <= 1'b0;
            link_rst_q <= 1'b1;
        end
        else
        begin
            prev_q <= line_q;
            if (start_ev)
            begin
                busy_q <= 1'b1;
                link_rst_q <= 1'b1;
            end
            else if (stop_ev)
            begin
                busy_q <= 1'b0;
                link_rst_q <= 1'b1;
            end
            else
                link_rst_q <= !busy_q;
        end
    end

    // quiet timer reloaded by any edge on either bus line
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            act_q <= '0;
        else if (line_q != prev_q)
            act_q <= QUIET_CYC;
        else if (act_q != 8'h00)
            act_q <= act_q - 8'h01;
    end

    // hold-off requests, each gated by its own delay bit
    assign samp_hold = !setup_q[SAMP_DLY_BIT] && act_q != 8'h00;
    assign trial_hold = !setup_q[TRIAL_DLY_BIT] && act_q != 8'h00;

    // ------------------------------------------------------------
    // serial slave on the bus clock and its event crossing
    // ------------------------------------------------------------

    acc_link u_link (
        .scl_clk(scl_clk),
        .link_rst(link_rst_q),
        .rst(rst),
        .sda_in(sda_in),
        .dev_addr(DEV_ADDR),
        .res_word(res_q),
        .sda_oe(sda_oe),
        .cfg_byte(link_cfg),
        .cfg_tgl(link_cfg_tgl),
        .rd_tgl(link_rd_tgl)
    );

    // toggles cross by two flops; the byte is stable while its toggle settles
    acc_sync #(
        .W(2)
    ) u_tgl_sync (
        .clk(sys_clk),
        .rst(rst),
        .d({link_rd_tgl, link_cfg_tgl}),
        .q(tgl_s)
    );

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            tgl_prev_q <= '0;
        else
            tgl_prev_q <= tgl_s;
    end

    assign cfg_ev = tgl_s[0] ^ tgl_prev_q[0];
    assign rd_ev = tgl_s[1] ^ tgl_prev_q[1];

    // ------------------------------------------------------------
    // setup register and channel sequencing
    // ------------------------------------------------------------

    // write-only setup, loaded from the first written data byte
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            setup_q <= CFG_RESET;
        else if (cfg_ev)
            setup_q <= link_cfg;
    end

    // input 3 is lost to the reference when the external reference is chosen
    assign ch_en = setup_q[CH_LSB +: CH_NUM] & {~setup_q[REF_BIT], 3'b111};

    // next enabled input above the last one converted, wrapping upward
    always_comb
    begin
        nxt_ch = ch_q;
        for (int k = CH_NUM; k >= 1; k--)
        begin
            if (ch_en[2'(ch_q + 2'(k))])
                nxt_ch = 2'(ch_q + 2'(k));
        end
    end

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------

    // wake, acquire, hold, trial each bit, store result, power down
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            ch_q <= 2'd3;
            cnt_q <= '0;
            bit_q <= '0;
            code_q <= '0;
            dly_q <= '0;
            abort_q <= 1'b0;
            res_q <= '0;
        end
        else
        begin
            abort_q <= 1'b0;
            if (cfg_ev && state_q == ST_IDLE)
                ch_q <= 2'd3; // restart sequence at the lowest input
            case (state_q)
                ST_IDLE:
                begin
                    if (rd_ev && |ch_en)
                    begin
                        state_q <= ST_WAKE;
                        ch_q <= nxt_ch;
                        cnt_q <= WAKE_CYC;
                        code_q <= '0;
                        dly_q <= '0;
                    end
                    else if (rd_ev)
                        res_q <= '0; // nothing selected: empty result
                end
                ST_WAKE:
                begin
                    if (cnt_q == 8'h01)
                        state_q <= ST_SAMPLE;
                    else
                        cnt_q <= cnt_q - 8'h01;
                end
                ST_SAMPLE:
                begin
                    if (!samp_hold)
                    begin
                        state_q <= ST_TRIAL;
                        bit_q <= 4'(CODE_W - 1);
                        code_q <= CODE_W'(1) << (CODE_W - 1);
                        cnt_q <= TRIAL_CYC;
                    end
                end
                ST_TRIAL:
                begin
                    if (cnt_q != 8'h01)
                        cnt_q <= cnt_q - 8'h01;
                    else if (trial_hold && dly_q == DLY_MAX_CYC)
                    begin
                        state_q <= ST_DONE;
                        abort_q <= 1'b1;
                        code_q <= '0;
                    end
                    else if (trial_hold)
                        dly_q <= dly_q + 8'h01;
                    else
                    begin
                        code_q[bit_q] <= comp_s;
                        if (bit_q == 4'd0)
                            state_q <= ST_DONE;
                        else
                        begin
                            code_q[bit_q - 4'd1] <= 1'b1;
                            bit_q <= bit_q - 4'd1;
                            cnt_q <= TRIAL_CYC;
                        end
                    end
                end
                ST_DONE:
                begin
                    res_q <= {2'b00, ch_q, code_q};
                    state_q <= ST_IDLE;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // clock stretching while the result is not ready
    // ------------------------------------------------------------

    // hold the bus clock low from the read request until the result stands
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            stretch_q <= 1'b0;
            scl_oe_q <= 1'b0;
        end
        else
        begin
            if (rd_ev && |ch_en && state_q == ST_IDLE)
                stretch_q <= 1'b1;
            else if (state_q == ST_DONE)
                stretch_q <= 1'b0;
            scl_oe_q <= stretch_q && (scl_oe_q || !line_q[0]);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------

    assign scl_out = 1'b0;
    assign scl_oe = scl_oe_q;
    assign sda_out = 1'b0;
    assign dac_code = code_q;
    assign track_en = state_q == ST_WAKE || state_q == ST_SAMPLE;
    assign power_up = state_q != ST_IDLE;
    assign mux_sel = ch_q;
    assign input_select_bits = setup_q[CH_LSB +: CH_NUM];
    assign ref_from_shared_pin = setup_q[REF_BIT];
    assign bus_glitch_filter_bypass = setup_q[FLT_BIT];
    assign conv_abort = abort_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------

    a_setup_reset_val: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(rst) |-> setup_q == CFG_RESET) else $error("setup not f0 after reset");

    a_setup_first_byte: assert property (@(posedge sys_clk) disable iff (rst)
        cfg_ev |=> setup_q == $past(link_cfg)) else $error("setup byte not stored");

    a_wake_length: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(state_q == ST_WAKE) |-> ##99 state_q == ST_WAKE ##1 state_q == ST_SAMPLE)
        else $error("wake time wrong");

    a_auto_shutdown: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == ST_DONE |=> state_q == ST_IDLE && !power_up) else $error("no shutdown after conversion");

    a_hold_sample: assert property (@(posedge sys_clk) disable iff (rst)
        (state_q == ST_SAMPLE ##1 state_q == ST_TRIAL) |-> !track_en [*8]) else $error("sample not held");

    a_seq_ascend: assert property (@(posedge sys_clk) disable iff (rst)
        rd_ev && state_q == ST_IDLE && ch_en == 4'b0011 && ch_q == 2'd0 |=> ch_q == 2'd1)
        else $error("sequence not ascending");

    a_ref_three_in: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(state_q == ST_WAKE) && setup_q[REF_BIT] && !$past(cfg_ev) |-> mux_sel != 2'd3)
        else $error("reference input converted");

    a_abort_limit: assert property (@(posedge sys_clk) disable iff (rst)
        abort_q |-> $past(dly_q) == DLY_MAX_CYC && state_q == ST_DONE) else $error("abort at wrong delay");

    a_result_format: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == ST_DONE |=> res_q == {2'b00, $past(ch_q), $past(code_q)}) else $error("result format wrong");

    a_stretch_release: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == ST_DONE |-> ##2 !scl_oe) else $error("clock not released");
endmodule

`default_nettype wire

// *** logic/acc_pkg.sv ***
// package: layout, reset value and timing of the converter setup and conversion control
`default_nettype none

package acc_pkg;

    // ------------------------------------------------------------
    // setup register layout
    // ------------------------------------------------------------
    localparam logic [7:0] CFG_RESET = 8'hf0;
    localparam int CH_LSB = 4;
    localparam int CH_NUM = 4;
    localparam int REF_BIT = 3;
    localparam int FLT_BIT = 2;
    localparam int TRIAL_DLY_BIT = 1;
    localparam int SAMP_DLY_BIT = 0;

    // ------------------------------------------------------------
    // result word and bus address
    // ------------------------------------------------------------
    localparam int CODE_W = 12;
    localparam int RES_W = 16;
    localparam logic [6:0] DEV_ADDR_DEF = 7'h28;

    // ------------------------------------------------------------
    // timing, in ns and in sys_clk cycles
    // ------------------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int WAKE_NS = 1000;
    localparam int CONV_NS = 2000;
    localparam int DLY_MAX_NS = 1000;
    localparam int QUIET_NS = 80;
    localparam logic [7:0] WAKE_CYC = 8'((WAKE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] TRIAL_CYC = 8'(CONV_NS / (CLK_NS * CODE_W));
    localparam logic [7:0] DLY_MAX_CYC = 8'(DLY_MAX_NS / CLK_NS);
    localparam logic [7:0] QUIET_CYC = 8'((QUIET_NS + CLK_NS - 1) / CLK_NS);
    localparam int FILT_LEN = 2;

    // conversion sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAKE = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_TRIAL = 3'b011,
        ST_DONE = 3'b100
    } acc_state_t;

endpackage

`default_nettype wire

// *** logic/acc_sync.sv ***
// two-flop synchroniser for levels entering the sys_clk domain
`default_nettype none

module acc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second stage; no reset on purpose: both stages
    // keep following the input while reset is held, so the idle level of a pin
    // is already in place when reset ends and no false edge follows it
    always_ff @(posedge clk)
    begin
        meta_q <= d;
        q <= meta_q;
    end
endmodule

`default_nettype wire

// *** logic/acc_link.sv ***
// serial slave end running on the bus clock: address, setup byte, result bytes
`default_nettype none

module acc_link (
    input wire logic scl_clk,
    input wire logic link_rst,
    input wire logic rst,
    input wire logic sda_in,
    input wire logic [6:0] dev_addr,
    input wire logic [acc_pkg::RES_W-1:0] res_word,
    output logic sda_oe,
    output logic [7:0] cfg_byte,
    output logic cfg_tgl,
    output logic rd_tgl
);
    import acc_pkg::*;

    logic [3:0] bit_q;
    logic [6:0] sh_q;
    logic [1:0] byte_q;
    logic match_q;
    logic rw_q;
    logic nak_q;
    logic [7:0] full;
    logic [7:0] dbyte;

    assign full = {sh_q, sda_in};
    assign dbyte = (byte_q == 2'd1) ? res_word[15:8] : res_word[7:0];

    // bit and byte counting, address match; cleared by each start or stop
    always_ff @(posedge scl_clk or posedge link_rst)
    begin
        if (link_rst)
        begin
            bit_q <= '0;
            sh_q <= '0;
            byte_q <= '0;
            match_q <= 1'b0;
            rw_q <= 1'b0;
            nak_q <= 1'b0;
        end
        else if (bit_q == 4'd8)
        begin
            bit_q <= '0;
            if (byte_q != 2'd3)
                byte_q <= byte_q + 2'd1;
            if (rw_q && byte_q != 2'd0 && sda_in)
                nak_q <= 1'b1; // master ends the read
        end
        else
        begin
            bit_q <= bit_q + 4'd1;
            sh_q <= full[6:0];
            if (bit_q == 4'd7 && byte_q == 2'd0)
            begin
                match_q <= full[7:1] == dev_addr;
                rw_q <= full[0];
            end
        end
    end

    // events toward the sys_clk domain, held across frames
    always_ff @(posedge scl_clk or posedge rst)
    begin
        if (rst)
        begin
            cfg_byte <= CFG_RESET;
            cfg_tgl <= 1'b0;
            rd_tgl <= 1'b0;
        end
        else if (bit_q == 4'd7)
        begin
            if (byte_q == 2'd0 && full[7:1] == dev_addr && full[0])
                rd_tgl <= ~rd_tgl;
            if (byte_q == 2'd1 && match_q && !rw_q)
            begin
                cfg_byte <= full;
                cfg_tgl <= ~cfg_tgl;
            end
        end
    end

    // data line drive, changed only while the clock is low
    always_ff @(negedge scl_clk or posedge link_rst)
    begin
        if (link_rst)
            sda_oe <= 1'b0;
        else if (!match_q)
            sda_oe <= 1'b0;
        else if (bit_q == 4'd8)
            sda_oe <= !rw_q || byte_q == 2'd0;
        else if (rw_q && byte_q != 2'd0 && !nak_q)
            sda_oe <= ~dbyte[~bit_q[2:0]];
        else
            sda_oe <= 1'b0;
    end
endmodule

`default_nettype wire

// *** sim/acc_host_model.sv ***
// bus master model: drives the two-wire bus at a 160 ns bit period
`default_nettype none

module acc_host_model (
    input wire logic scl_wire,
    input wire logic sda_wire,
    output logic scl_low,
    output logic sda_low,
    output logic hang
);
    timeunit 1ns;
    timeprecision 1ps;

    // both lines released; clock stands still outside frames
    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        hang = 1'b0;
    end

    // start condition, clock held high long enough for the slave to see it
    task automatic start_cond();
        sda_low = 1'b1;
        #120 scl_low = 1'b1;
    endtask

    // one bit: data set while low, clock released, stretching waited out
    task automatic bit_xfer(input logic b, output logic r);
        int n;
        n = 0;
        #40 sda_low = ~b;
        #40 scl_low = 1'b0;
        while (scl_wire !== 1'b1 && n < 2000)
        begin
            #10 n++;
        end
        if (n == 2000)
            hang = 1'b1;
        #40 r = sda_wire;
        #40 scl_low = 1'b1;
    endtask

    // stop condition leaves both lines high
    task automatic stop_cond();
        #40 sda_low = 1'b1;
        #40 scl_low = 1'b0;
        #80 sda_low = 1'b0;
        #80;
    endtask

    // one byte msb first, then the acknowledge slot
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_xfer(d[i], r);
        bit_xfer(1'b1, r);
        ack = ~r;
    endtask

    // one byte read; the last one is answered with no acknowledge
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_xfer(1'b1, d[i]);
        bit_xfer(last, r);
    endtask
endmodule

`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench: setup writes and converting reads through the bus model
`default_nettype none

`define CHK(what, ex, got) \
    begin \
        checked++; \
        if ((got) !== (ex)) \
        begin \
            $display("unexpected %s: expected %h seen %h", what, ex, got); \
            mismatches++; \
        end \
    end

module tb_top;
    import acc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic comp_in = 1'b0;
    logic scl_oe, sda_oe, scl_low, sda_low, hang, scl_out, sda_out, conv_abort;
    logic track_en, power_up, ref_pin, bypass, ack;
    logic [CODE_W-1:0] dac_code;
    logic [1:0] mux_sel, last;
    logic [CH_NUM-1:0] sel_bits;
    logic [7:0] cfg, b1, b2;
    logic [11:0] ain [4];
    logic [7:0] corner [4] = '{8'hf0, 8'h00, 8'h8f, 8'h38};
    int mismatches = 0;
    int checked = 0;
    int pu_cyc = 0;
    logic abort_seen = 1'b0;
    wire scl_wire = ~(scl_oe | scl_low);
    wire sda_wire = ~(sda_oe | sda_low);

    always #5 sys_clk = ~sys_clk;

    acc_ctrl DUT (
        .sys_clk(sys_clk),
        .rst(rst),
        .scl_clk(scl_wire),
        .scl_out(scl_out),
        .scl_oe(scl_oe),
        .sda_in(sda_wire),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .comp_in(comp_in),
        .dac_code(dac_code),
        .track_en(track_en),
        .power_up(power_up),
        .mux_sel(mux_sel),
        .input_select_bits(sel_bits),
        .ref_from_shared_pin(ref_pin),
        .bus_glitch_filter_bypass(bypass),
        .conv_abort(conv_abort)
    );

    acc_host_model host (
        .scl_wire(scl_wire),
        .sda_wire(sda_wire),
        .scl_low(scl_low),
        .sda_low(sda_low),
        .hang(hang)
    );

    // comparator: high while the held input is at or above the trial level
    always @(negedge sys_clk)
        comp_in <= (ain[mux_sel] >= dac_code);

    // counts awake cycles of the current read and notes any abandoned conversion
    always @(posedge sys_clk)
    begin
        pu_cyc <= pu_cyc + int'(power_up);
        abort_seen <= abort_seen | conv_abort;
    end

    // next input of the sequence, or 4 when none is usable
    function automatic int next_ch(logic [7:0] c, logic [1:0] prev);
        logic [3:0] en;
        int k;
        en = c[7:4] & (c[3] ? 4'h7 : 4'hf);
        for (int i = 1; i <= 4; i++)
        begin
            k = (prev + i) % 4;
            if (en[k])
                return k;
        end
        return 4;
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // setup write, optionally with a spare byte that must be ignored
    task automatic write_cfg(logic [6:0] addr, logic [7:0] d, logic extra);
        host.start_cond();
        host.send_byte({addr, 1'b0}, ack);
        `CHK("address ack", addr == DEV_ADDR_DEF, ack)
        host.send_byte(d, ack);
        if (extra)
            host.send_byte(~d, ack);
        host.stop_cond();
        repeat (10) @(negedge sys_clk);
    endtask

    // one converting read of two bytes
    task automatic read_res(int ch);
        logic [15:0] ew;
        ew = (ch == 4) ? 16'h0000 : {2'b00, 2'(ch), ain[ch[1:0]]};
        pu_cyc = 0;
        abort_seen = 1'b0;
        host.start_cond();
        host.send_byte({DEV_ADDR_DEF, 1'b1}, ack);
        host.get_byte(1'b0, b1);
        host.get_byte(1'b1, b2);
        host.stop_cond();
        `CHK("result", ew, {b1, b2})
        `CHK("awake time", ch != 4, pu_cyc >= 292)
        `CHK("shutdown", 1'b0, power_up)
        `CHK("abort", 1'b0, abort_seen)
    endtask

    // a hung bus ends the run
    always @(posedge hang)
    begin
        mismatches++;
        results();
    end

    initial
    begin
        int ch;
        void'($urandom(79277));
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        repeat (5) @(negedge sys_clk);
        `CHK("select", 4'hf, sel_bits)
        `CHK("reference", 1'b0, ref_pin)
        `CHK("bypass", 1'b0, bypass)
        `CHK("awake", 1'b0, power_up)
        `CHK("tracking", 1'b0, track_en)
        `CHK("drive level", 2'b00, {scl_out, sda_out})
        for (int t = 0; t < 10; t++)
        begin
            // corners first, then random setups, some with no usable input
            cfg = (t < 4) ? corner[t] : 8'($urandom);
            if (t >= 4 && cfg[3])
                cfg[7] = 1'b0;
            if (t > 0)
                write_cfg(DEV_ADDR_DEF, cfg, t == 2);
            `CHK("select", cfg[7:4], sel_bits)
            `CHK("reference", cfg[3], ref_pin)
            `CHK("bypass", cfg[2], bypass)
            last = 2'd3;
            for (int r = 0; r < 5; r++)
            begin
                for (int i = 0; i < 4; i++)
                    ain[i] = 12'($urandom);
                ch = next_ch(cfg, last);
                read_res(ch);
                if (ch < 4)
                    last = 2'(ch);
            end
            // a setup write to another address leaves the setup alone
            write_cfg(DEV_ADDR_DEF ^ 7'h01, ~cfg, 1'b0);
            `CHK("select kept", cfg[7:4], sel_bits)
            $display("test %0d done", t);
        end
        // a second reset restores the power-up setup and restarts the sequence
        rst = 1'b1;
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        repeat (5) @(negedge sys_clk);
        `CHK("select", 4'hf, sel_bits)
        `CHK("awake", 1'b0, power_up)
        read_res(0);
        $display("reset test done");
        results();
    end
endmodule

`default_nettype wire
